// File: hdl/sdc_axil.sv
`timescale 1ns/1ps
// axi4-lite slave front end; one write and one read at a time
module sdc_axil
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // read channels
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // register side
  output logic wr_pulse,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_pulse,
  output logic [3:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  typedef struct packed
  {
    logic aw_have;
    logic w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sdc_axil_t;
  sdc_axil_t r;
  sdc_axil_t next_r;
  logic do_wr;

  assign s_awready = !r.aw_have && !r.bvalid;
  assign s_wready = !r.w_have && !r.bvalid;
  assign s_arready = !r.rvalid;
  assign s_bvalid = r.bvalid;
  assign s_bresp = r.bresp;
  assign s_rvalid = r.rvalid;
  assign s_rresp = r.rresp;
  assign s_rdata = r.rdata;
  assign do_wr = r.aw_have && r.w_have && !r.bvalid;
  assign wr_pulse = do_wr;
  assign wr_addr = r.awaddr;
  assign wr_data = r.wdata;
  assign wr_strb = r.wstrb;
  assign rd_pulse = s_arvalid && s_arready;
  assign rd_addr = s_araddr;

  always_comb
  begin
    next_r = r;
    if (s_awvalid && s_awready)
    begin
      next_r.aw_have = 1'b1;
      next_r.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      next_r.w_have = 1'b1;
      next_r.wdata = s_wdata;
      next_r.wstrb = s_wstrb;
    end
    if (do_wr)
    begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      // unmapped address answers slverr
      next_r.bresp = wr_ok ? 2'h0 : 2'h2;
    end
    if (r.bvalid && s_bready)
      next_r.bvalid = 1'b0;
    if (rd_pulse)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_data;
      next_r.rresp = rd_ok ? 2'h0 : 2'h2;
    end
    else if (r.rvalid && s_rready)
      next_r.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= next_r;
  end
endmodule

// File: hdl/sdc_master.sv
`timescale 1ns/1ps
// serial dma bus request sequencer: one longword per grant
module sdc_master
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // channel side
  input wire logic xfer_pending,
  // arbitration gates
  input wire logic hold_off,
  input wire logic halt,
  // module bus
  input wire logic bus_grant,
  input wire logic cycle_done,
  output logic bus_request_line,
  output logic bus_master
);
  typedef struct packed
  {
    sdc_pkg::sdc_mstate_t st;
  } sdc_master_t;
  sdc_master_t r;
  sdc_master_t next_r;

  assign bus_request_line = (r.st == sdc_pkg::SDC_REQ) && !hold_off; // [RULE4] [RULE5]
  assign bus_master = (r.st == sdc_pkg::SDC_XFER);

  always_comb
  begin
    next_r = r;
    case (r.st)
      sdc_pkg::SDC_IDLE:
        if (xfer_pending && !halt)
          next_r.st = sdc_pkg::SDC_REQ;
      sdc_pkg::SDC_REQ:
        if (halt)
          next_r.st = sdc_pkg::SDC_HALT;
        else if (bus_grant && !hold_off)
          next_r.st = sdc_pkg::SDC_XFER;
      sdc_pkg::SDC_XFER:
        // one longword, then give the bus back
        if (halt)
          next_r.st = sdc_pkg::SDC_HALT; // [RULE19]
        else if (cycle_done)
          next_r.st = sdc_pkg::SDC_IDLE; // [RULE20]
      sdc_pkg::SDC_HALT:
        if (!halt)
          next_r.st = sdc_pkg::SDC_IDLE;
      default:
        next_r.st = sdc_pkg::SDC_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r.st <= sdc_pkg::SDC_IDLE;
    else
      r <= next_r;
  end
endmodule

// File: hdl/sdc_top.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// shared serial dma control and status registers
module sdc_top
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // channel events
  input wire logic xfer_pending,
  input wire logic bus_grant,
  input wire logic cycle_done,
  input wire logic cycle_error,
  input wire logic [31:0] cycle_address,
  input wire logic breakpoint,
  input wire logic factory_test_event,
  // system
  input wire logic freeze,
  input wire logic [2:0] service_level,
  input wire logic processor_irq_mask,
  input wire logic processor_reset,
  // outputs
  output logic bus_request_line,
  output logic bus_master,
  output logic [2:0] arbitration_priority,
  output logic processor_halted,
  output logic irq
);
  typedef struct packed
  {
    logic [15:0] serial_dma_config;
    logic [7:0] serial_dma_event_status;
    logic [31:0] serial_dma_fault_address;
    logic halted;
  } sdc_regs_t;
  sdc_regs_t r;
  sdc_regs_t next_r;

  logic wr_pulse;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_pulse;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic [1:0] freeze_response_field;
  logic [2:0] interrupt_service_mask;
  logic error_interrupt_enable;
  logic breakpoint_interrupt_enable;
  logic freeze_hold;
  logic hold_off;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [15:0] cfg_wmask;

  function automatic logic mapped(input logic [3:0] a);
    if (a == sdc_pkg::SDC_OFF_CONFIG)
      mapped = 1'b1;
    else if (a == sdc_pkg::SDC_OFF_STATUS)
      mapped = 1'b1;
    else if (a == sdc_pkg::SDC_OFF_FAULT)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  endfunction

  sdc_axil u_axil
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_pulse(rd_pulse),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  assign freeze_response_field = r.serial_dma_config[sdc_pkg::SDC_FRZ_LSB +: 2];
  assign interrupt_service_mask = r.serial_dma_config[sdc_pkg::SDC_INTERRUPT_SERVICE_MASK_LSB +: 3];
  assign error_interrupt_enable = r.serial_dma_config[sdc_pkg::SDC_ERROR_INTERRUPT_ENABLE_BIT];
  assign breakpoint_interrupt_enable = r.serial_dma_config[sdc_pkg::SDC_BREAKPOINT_INTERRUPT_ENABLE_BIT];
  assign arbitration_priority = r.serial_dma_config[sdc_pkg::SDC_SAID_LSB +: 3]; // [RULE7]

  // reserved freeze codes behave as ignore
  assign freeze_hold = freeze && (freeze_response_field == sdc_pkg::SDC_FRZ_STOP); // [RULE3]
  assign hold_off = freeze_hold || (service_level > interrupt_service_mask); // [RULE4] [RULE5]

  sdc_master u_master
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .xfer_pending(xfer_pending),
    .hold_off(hold_off),
    .halt(r.halted),
    .bus_grant(bus_grant),
    .cycle_done(cycle_done),
    .bus_request_line(bus_request_line),
    .bus_master(bus_master)
  );

  assign processor_halted = r.halted;
  assign irq = processor_irq_mask &&
    ((r.serial_dma_event_status[sdc_pkg::SDC_BUS_ERROR_FLAG_BIT] && error_interrupt_enable) ||
     (r.serial_dma_event_status[sdc_pkg::SDC_BREAKPOINT_FLAG_BIT] && breakpoint_interrupt_enable));
  // [RULE9] [RULE10] [RULE11] [RULE21]

  assign rd_ok = mapped(rd_addr);
  assign wr_ok = mapped(wr_addr);

  always_comb
  begin
    if (rd_addr == sdc_pkg::SDC_OFF_CONFIG)
      rd_data = {16'h0000, r.serial_dma_config};
    else if (rd_addr == sdc_pkg::SDC_OFF_STATUS)
      rd_data = {24'h000000, r.serial_dma_event_status}; // [RULE13]
    else if (rd_addr == sdc_pkg::SDC_OFF_FAULT)
      rd_data = r.serial_dma_fault_address;
    else
      rd_data = 32'h00000000;
  end

  always_comb
  begin
    set_bits = 8'h00;
    set_bits[sdc_pkg::SDC_BUS_ERROR_FLAG_BIT] = bus_master && cycle_error; // [RULE12] [RULE14]
    set_bits[sdc_pkg::SDC_BREAKPOINT_FLAG_BIT] = bus_master && breakpoint; // [RULE15]
    set_bits[sdc_pkg::SDC_FACTORY_TEST_FLAG_BIT] = factory_test_event; // [RULE17]
    clr_bits = 8'h00;
    if (wr_pulse && (wr_addr == sdc_pkg::SDC_OFF_STATUS) && wr_strb[0])
      clr_bits = wr_data[7:0] & sdc_pkg::SDC_STATUS_MASK; // [RULE13]
    cfg_wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & sdc_pkg::SDC_CONFIG_MASK; // [RULE18]
  end

  always_comb
  begin
    next_r = r;
    if (wr_pulse && (wr_addr == sdc_pkg::SDC_OFF_CONFIG))
      next_r.serial_dma_config = (r.serial_dma_config & ~cfg_wmask) |
        (wr_data[15:0] & cfg_wmask); // [RULE1]
    // set wins over a simultaneous clear
    next_r.serial_dma_event_status = ((r.serial_dma_event_status & ~clr_bits) | set_bits)
      & sdc_pkg::SDC_STATUS_MASK; // [RULE12] [RULE18]
    if (bus_master && cycle_error)
    begin
      next_r.serial_dma_fault_address = cycle_address; // [RULE14] [RULE16]
      next_r.halted = 1'b1; // [RULE19]
    end
    else if (processor_reset)
      next_r.halted = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r.serial_dma_config <= sdc_pkg::SDC_CONFIG_RESET; // [RULE1]
      r.serial_dma_event_status <= sdc_pkg::SDC_STATUS_RESET; // [RULE13]
      r.serial_dma_fault_address <= sdc_pkg::SDC_FAULT_RESET;
      r.halted <= 1'b0;
    end
    else
      r <= next_r;
  end
endmodule

// File: pkg/sdc_pkg.sv
// What this block and the software that drives it must do
// RULE1 - sixteen-bit config register, reset to zero
// RULE2 - software changes config only while processor disabled
// RULE3 - freeze field: 00 ignore, 10 stop
// RULE4 - on freeze, drop bus request until negated
// RULE5 - service level above mask releases bus request
// RULE6 - software sets service mask to seven
// RULE7 - arbitration id drives shared bus priority
// RULE8 - software sets arbitration id four, seven slave
// RULE9 - bus error sets flag, interrupt if enabled
// RULE10 - breakpoint sets flag, interrupt if enabled
// RULE11 - interrupt reaches controller only when processor mask set
// RULE12 - eight-bit status sets bits regardless of enables
// RULE13 - status readable, write one clears, reset clears
// RULE14 - bus error flag set, fault address captured
// RULE15 - breakpoint during transfer sets breakpoint flag
// RULE16 - read-only fault address register
// RULE17 - factory test flag behaves like other flags
// RULE18 - reserved config and status bits carry nothing
// RULE19 - bus error halts processor until command reset
// RULE20 - one longword per grant, then release
// RULE21 - interrupt level from flag and enable pairs
package sdc_pkg;
  localparam logic [3:0] SDC_OFF_CONFIG = 4'h0;
  localparam logic [3:0] SDC_OFF_STATUS = 4'h4;
  localparam logic [3:0] SDC_OFF_FAULT = 4'h8;
  localparam logic [15:0] SDC_CONFIG_RESET = 16'h0000;
  localparam logic [7:0] SDC_STATUS_RESET = 8'h00;
  // fault address has no defined reset value; zero keeps reads repeatable
  localparam logic [31:0] SDC_FAULT_RESET = 32'h00000000;
  localparam logic [15:0] SDC_CONFIG_MASK = 16'h6F7B;
  localparam logic [7:0] SDC_STATUS_MASK = 8'h07;
  localparam int SDC_FRZ_LSB = 13;
  localparam int SDC_INTERRUPT_SERVICE_MASK_LSB = 8;
  localparam int SDC_SAID_LSB = 4;
  localparam int SDC_ERROR_INTERRUPT_ENABLE_BIT = 1;
  localparam int SDC_BREAKPOINT_INTERRUPT_ENABLE_BIT = 0;
  localparam int SDC_FACTORY_TEST_FLAG_BIT = 2;
  localparam int SDC_BUS_ERROR_FLAG_BIT = 1;
  localparam int SDC_BREAKPOINT_FLAG_BIT = 0;
  localparam logic [1:0] SDC_FRZ_IGNORE = 2'h0;
  localparam logic [1:0] SDC_FRZ_STOP = 2'h2;
  typedef enum logic [1:0]
  {
    SDC_IDLE = 2'b00,
    SDC_REQ = 2'b01,
    SDC_XFER = 2'b10,
    SDC_HALT = 2'b11
  } sdc_mstate_t;
endpackage

// File: tb/sdc_arbiter_model.sv
`timescale 1ns/1ps
// arbiter and memory: grants a request, ends each longword
module sdc_arbiter_model
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench controls
  input wire logic grant_en,
  input wire logic err_en,
  input wire logic [1:0] wait_n,
  input wire logic [31:0] f_addr,
  // design side
  input wire logic bus_request_line,
  input wire logic bus_master,
  output logic bus_grant,
  output logic cycle_done,
  output logic cycle_error,
  output logic [31:0] cycle_address
);
  logic [1:0] n;
  // inverted outside a cycle so a stale capture shows
  assign cycle_address = bus_master ? f_addr : ~f_addr;
  always_ff @(posedge aclk)
  begin
    bus_grant <= aresetn && grant_en && bus_request_line;
    cycle_done <= 1'h0;
    cycle_error <= 1'h0;
    n <= 2'h0;
    if (aresetn && bus_master && !cycle_done)
    begin
      n <= n + 2'h1;
      if (n == wait_n)
      begin
        cycle_done <= 1'h1;
        cycle_error <= err_en;
      end
    end
  end
endmodule

// File: tb/sdc_top_asserts.sv
`timescale 1ns/1ps
module sdc_top_asserts
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus answers
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // module bus and system
  input wire logic bus_grant,
  input wire logic cycle_done,
  input wire logic cycle_error,
  input wire logic processor_irq_mask,
  input wire logic processor_reset,
  input wire logic bus_request_line,
  input wire logic bus_master,
  input wire logic processor_halted,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_won;
    bus_request_line && bus_grant;
  endsequence
  sequence s_fault;
    bus_master && cycle_error;
  endsequence
  property p_grant;
    s_won |=> bus_master;
  endproperty
  property p_release;
    bus_master && cycle_done |=> !bus_master;
  endproperty
  property p_fault;
    s_fault |=> processor_halted ##0 !bus_request_line;
  endproperty
  property p_halt_hold;
    processor_halted && !processor_reset |=> processor_halted;
  endproperty
  property p_unhalt;
    processor_reset && !bus_master |=> !processor_halted;
  endproperty
  property p_halt_quiet;
    processor_halted |-> !bus_request_line && !bus_master;
  endproperty
  property p_irq_mask;
    !processor_irq_mask |-> !irq;
  endproperty
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  property p_rhold;
    s_rvalid && !s_rready |=> $stable(s_rvalid);
  endproperty
  a_grant: assert property (p_grant) else $error("grant without mastership");
  a_release: assert property (p_release) else $error("bus kept after longword");
  a_fault: assert property (p_fault) else $error("bus error did not halt");
  a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
  a_unhalt: assert property (p_unhalt) else $error("halt not cleared");
  a_halt_quiet: assert property (p_halt_quiet) else $error("request while halted");
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule
bind sdc_top sdc_top_asserts sdc_top_asserts_i (.*);

// File: tb/sdc_top_bench.sv
`timescale 1ns/1ps
module sdc_top_bench;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hF;
  logic [31:0] s_wdata = 32'h0, f_addr = 32'h0, s_rdata, cycle_address, rd;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, bus_grant, cycle_done;
  logic [1:0] s_bresp, s_rresp, rsp, wait_n = 2'h0;
  logic xfer_pending = 0, cycle_error, breakpoint = 0, factory_test_event = 0;
  logic freeze = 0, processor_irq_mask = 0, processor_reset = 0, grant_en = 0;
  logic [2:0] service_level = 3'h0, arbitration_priority;
  logic bus_request_line, bus_master, processor_halted, irq, err_en = 0;
  int n_mismatch = 0, n_checks = 0, seed = 84, cfg = 0, sts = 0, far = 0, i, step = 0;
  always #5 aclk = ~aclk;
  sdc_top sdc_top_i (.*);
  sdc_arbiter_model sdc_arbiter_model_i (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // each channel released only on the edge it was taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw = 1'h1, w = 1'h1, b = 1'h1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (b)
    begin
      @(negedge aclk);
      aw = aw && !s_awready;
      w = w && !s_wready;
      b = !s_bvalid;
      rsp = s_bresp;
      @(posedge aclk);
      s_awvalid <= aw;
      s_wvalid <= w;
      s_bready <= b;
    end
    if (a == sdc_pkg::SDC_OFF_CONFIG)
      cfg = d[15:0] & sdc_pkg::SDC_CONFIG_MASK;
    if (a == sdc_pkg::SDC_OFF_STATUS)
      sts = sts & ~d;
    chk("bresp", rsp, a == 4'hC ? 2 : 0);
  endtask
  task automatic rd_bus(input logic [3:0] a);
    logic ar = 1'h1, r = 1'h1;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    while (r)
    begin
      @(negedge aclk);
      ar = ar && !s_arready;
      r = !s_rvalid;
      rd = s_rdata;
      rsp = s_rresp;
      @(posedge aclk);
      s_arvalid <= ar;
      s_rready <= r;
    end
  endtask
  task automatic chk_all();
    int a;
    for (a = 0; a < 16; a += 4)
    begin
      rd_bus(a[3:0]);
      chk("rdata", rd, a == 0 ? cfg : a == 4 ? sts : a == 8 ? far : 0);
      chk("rresp", rsp, a > 8 ? 2 : 0);
    end
    @(negedge aclk);
    chk("prio", arbitration_priority, cfg[6:4]);
    chk("irq", irq, processor_irq_mask && (cfg & sts & 3) != 0);
    $display("step %0d done", ++step);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    chk_all();
    for (i = 0; i < 8; i++)
    begin
      wr({i[1:0], 2'h0}, $random(seed));
      chk_all();
    end
    xfer_pending <= 1'h1;
    for (i = 0; i < 4; i++)
    begin
      wr(4'h0, {i[1:0], 13'h0740});
      freeze <= 1'h1;
      repeat (2) @(posedge aclk);
      chk("frz", bus_request_line, i != 2);
      freeze <= 1'h0;
      repeat (2) @(posedge aclk);
      chk("unfrz", bus_request_line, 1);
    end
    wr(4'h0, 32'h0340);
    for (i = 0; i < 8; i++)
    begin
      service_level <= i[2:0];
      repeat (2) @(posedge aclk);
      chk("mask", bus_request_line, i <= 3);
    end
    wr(4'h0, 32'h0740);
    breakpoint <= 1'h1;
    grant_en <= 1'h1;
    wait_n <= 2'h2;
    repeat (12) @(posedge aclk);
    grant_en <= 1'h0;
    breakpoint <= 1'h0;
    sts = sts | 1;
    chk_all();
    processor_irq_mask <= 1'h1;
    wr(4'h0, 32'h0743);
    chk_all();
    processor_irq_mask <= 1'h0;
    chk_all();
    processor_irq_mask <= 1'h1;
    factory_test_event <= 1'h1;
    @(posedge aclk);
    factory_test_event <= 1'h0;
    sts = sts | 4;
    wr(4'h4, 32'h0);
    chk_all();
    wr(4'h4, 32'h5);
    chk_all();
    f_addr <= $random(seed);
    err_en <= 1'h1;
    grant_en <= 1'h1;
    wait_n <= 2'h0;
    repeat (8) @(posedge aclk);
    grant_en <= 1'h0;
    err_en <= 1'h0;
    sts = sts | 2;
    far = f_addr;
    chk_all();
    chk("halt", {processor_halted, bus_request_line}, 2);
    processor_reset <= 1'h1;
    @(posedge aclk);
    processor_reset <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("resume", {processor_halted, bus_request_line}, 1);
    final_report();
  end
  // whole run is a few hundred cycles
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
